// file: drbi_pkg.sv
package drbi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // memory organisation
    localparam int DRBI_DEPTH = 1024;
    localparam int DRBI_ADDR_W = 10;
    localparam int DRBI_WORD_W = 16;
    localparam int DRBI_LANE_W = 4;
    localparam int DRBI_LANES = 4;
    localparam int DRBI_GROUPS = 2;

    // reply capacity of one memory
    localparam int DRBI_MODES_REPLIES = 102;
    localparam int DRBI_MODES_WORDS = 10;
    localparam int DRBI_ATC_REPLIES = 256;
    localparam int DRBI_ATC_WORDS = 4;

    // controller burst lengths
    localparam logic [2:0] DRBI_BURST_FOUR = 3'h4;
    localparam logic [2:0] DRBI_BURST_SIX = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // apb register map (byte addresses)
    localparam int DRBI_PADDR_W = 8;
    localparam logic [7:0] DRBI_CTRL_OFS = 8'h00;
    localparam logic [7:0] DRBI_STATUS_OFS = 8'h04;
    localparam logic [7:0] DRBI_PTR1_OFS = 8'h08;
    localparam logic [7:0] DRBI_PTR2_OFS = 8'h0C;
    localparam logic [7:0] DRBI_DIAG_DATA_OFS = 8'h10;

    // control register fields
    localparam int DRBI_CTRL_WSEL_BIT = 0;
    localparam int DRBI_CTRL_DIAG_BIT = 1;
    localparam int DRBI_CTRL_SRST_BIT = 2;
    localparam int DRBI_CTRL_DINC_BIT = 3;

    // status register fields
    localparam int DRBI_STAT_ROLE_BIT = 0;
    localparam int DRBI_STAT_BUSY_BIT = 1;

    // pointer register fields
    localparam int DRBI_PTR_WR_LSB = 0;
    localparam int DRBI_PTR_RD_LSB = 16;

    localparam logic [31:0] DRBI_ZERO_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // indices of the synchronised event pins
    localparam int DRBI_EV_SWAP = 0;
    localparam int DRBI_EV_CLR = 1;
    localparam int DRBI_EV_WR = 2;
    localparam int DRBI_EV_N = 3;

    typedef struct packed {
        logic diag;
        logic wsel;
    } drbi_ctrl_t;

    typedef struct packed {
        logic [DRBI_ADDR_W-1:0] rd;
        logic [DRBI_ADDR_W-1:0] wr;
    } drbi_ptr_t;

endpackage

// file: drbi_top.sv
`timescale 1ns/1ps

// Contract
// - two identical buffer groups, each a 1024 by 16 memory with own counters
// - each memory built from four 4-bit wide, 1024 deep lanes side by side
// - exactly one group is primary at any time, the other secondary
// - every swap pulse from the uplink timer exchanges primary and secondary
// - reply controller only ever receives words from the primary memory
// - each memory holds 102 ten-word or 256 four-word replies
// - each memory has separate read and write address counters
// - per memory a multiplexer picks read or write counter as address
// - every address counter is 10 bits and wraps from maximum to zero
// - all address counters clear on power-up, software reset or missed clear
// - missed-interrogation clear discards precomputed replies in secondary
// - role line low means buffer one primary, high means buffer two
// - four or six word read drives that many primary words, advancing read pointer
// - buffer-role select steers host writes to primary or secondary group
// - write pointer increments once, one cycle enable, after each synced strobe
module drbi_top
    import drbi_pkg::*;
#(
    parameter int ADDR_W = DRBI_ADDR_W
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic [DRBI_PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // uplink interrogation timer pins
    input wire logic role_swap_pulse,
    input wire logic missed_interrogation_clear,
    // host write port pins
    input wire logic host_write_strobe,
    input wire logic [DRBI_WORD_W-1:0] host_wr_data,
    // reply output controller
    input wire logic read_four_words_cmd,
    input wire logic read_six_words_cmd,
    output logic [DRBI_WORD_W-1:0] reply_data,
    output logic reply_data_valid,
    // role indication
    output logic primary_is_two
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (ADDR_W != DRBI_ADDR_W
        || (1 << ADDR_W) < DRBI_MODES_REPLIES * DRBI_MODES_WORDS
        || (1 << ADDR_W) < DRBI_ATC_REPLIES * DRBI_ATC_WORDS
        || DRBI_LANES * DRBI_LANE_W != DRBI_WORD_W)
    begin : g_bad_cfg
        $error("drbi_top: unsupported address width or lane layout");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [DRBI_EV_N-1:0] ev_pin;
    logic [DRBI_EV_N-1:0] ev_s1_r;
    logic [DRBI_EV_N-1:0] ev_s2_r;
    logic [DRBI_EV_N-1:0] ev_s3_r;
    logic [DRBI_EV_N-1:0] ev_pulse;
    logic [DRBI_WORD_W-1:0] wdata_s1_r;
    logic [DRBI_WORD_W-1:0] wdata_s2_r;

    assign ev_pin[DRBI_EV_SWAP] = role_swap_pulse;
    assign ev_pin[DRBI_EV_CLR] = missed_interrogation_clear;
    assign ev_pin[DRBI_EV_WR] = host_write_strobe;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ev_s1_r <= '0;
            ev_s2_r <= '0;
            ev_s3_r <= '0;
            wdata_s1_r <= '0;
            wdata_s2_r <= '0;
        end
        else
        begin
            ev_s1_r <= ev_pin;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
            // data settles long before the synchronised strobe edge is seen
            wdata_s1_r <= host_wr_data;
            wdata_s2_r <= wdata_s1_r;
        end
    end

    // rising edges, one cycle each
    assign ev_pulse = ev_s2_r & ~ev_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state on every access

    drbi_ctrl_t ctrl_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic apb_access;
    logic apb_wr_done;
    logic addr_ok;
    logic soft_clr;
    logic diag_inc;
    logic [31:0] rd_mux;

    assign apb_access = psel & penable & ~pready_r;
    assign apb_wr_done = psel & penable & pready_r & pwrite & addr_ok;
    assign soft_clr = apb_wr_done & (paddr == DRBI_CTRL_OFS) & pwdata[DRBI_CTRL_SRST_BIT];
    assign diag_inc = apb_wr_done & (paddr == DRBI_CTRL_OFS) & pwdata[DRBI_CTRL_DINC_BIT];

    always_comb
    begin
        addr_ok = 1'b1;
        case (paddr)
            DRBI_CTRL_OFS, DRBI_STATUS_OFS, DRBI_PTR1_OFS, DRBI_PTR2_OFS,
            DRBI_DIAG_DATA_OFS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready_r <= 1'b0;
            prdata_r <= DRBI_ZERO_WORD;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= apb_access;
            pslverr_r <= apb_access & ~addr_ok;
            if (apb_access && !pwrite)
                prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_r <= '0;
        else if (apb_wr_done && paddr == DRBI_CTRL_OFS)
        begin
            ctrl_r.wsel <= pwdata[DRBI_CTRL_WSEL_BIT];
            ctrl_r.diag <= pwdata[DRBI_CTRL_DIAG_BIT];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // role designation

    logic role_r;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            role_r <= 1'b0;
        else if (ev_pulse[DRBI_EV_SWAP])
            role_r <= ~role_r;
    end

    assign primary_is_two = role_r;

    ////////////////////////////////////////////////////////////////////////////
    // buffer groups

    logic clr_all;
    logic wr_go;
    logic wr_target;
    logic diag_target;
    logic burst_active;
    logic [2:0] burst_cnt_r;
    logic [DRBI_GROUPS-1:0] wr_hit;
    logic [DRBI_GROUPS-1:0] rd_hit;
    logic [DRBI_GROUPS-1:0] wr_inc_r;
    logic [DRBI_GROUPS-1:0][DRBI_WORD_W-1:0] rd_word;
    drbi_ptr_t [DRBI_GROUPS-1:0] ptr_r;

    assign clr_all = soft_clr | ev_pulse[DRBI_EV_CLR];
    assign wr_go = ev_pulse[DRBI_EV_WR];
    assign wr_target = role_r ^ ctrl_r.wsel;
    assign diag_target = role_r ^ ctrl_r.wsel;
    assign burst_active = (burst_cnt_r != 3'h0) & ~ctrl_r.diag;

    genvar g;
    genvar ln;
    generate
        for (g = 0; g < DRBI_GROUPS; g++)
        begin : grp
            logic grp_id;
            logic is_pri;
            logic diag_hit;
            logic [ADDR_W-1:0] mem_addr;

            assign grp_id = 1'(g);
            assign is_pri = (role_r == grp_id);
            assign wr_hit[g] = wr_go & (wr_target == grp_id);
            // a host write owns the address port; the burst waits that cycle
            assign rd_hit[g] = burst_active & is_pri & ~wr_hit[g];
            assign diag_hit = diag_inc & ctrl_r.diag & (diag_target == grp_id);
            assign mem_addr = wr_hit[g] ? ptr_r[g].wr : ptr_r[g].rd;

            for (ln = 0; ln < DRBI_LANES; ln++)
            begin : lane
                logic [DRBI_LANE_W-1:0] lane_mem [DRBI_DEPTH];

                always_ff @(posedge sys_clk)
                begin
                    if (wr_hit[g])
                        lane_mem[mem_addr] <= wdata_s2_r[ln*DRBI_LANE_W +: DRBI_LANE_W];
                end

                assign rd_word[g][ln*DRBI_LANE_W +: DRBI_LANE_W] = lane_mem[mem_addr];
            end

            always_ff @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                    wr_inc_r[g] <= 1'b0;
                else
                    wr_inc_r[g] <= wr_hit[g];
            end

            // clear beats increment; both counters wrap naturally
            always_ff @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                    ptr_r[g] <= '0;
                else if (clr_all)
                    ptr_r[g] <= '0;
                else
                begin
                    if (wr_inc_r[g])
                        ptr_r[g].wr <= ptr_r[g].wr + 1'b1;
                    if (rd_hit[g] || diag_hit)
                        ptr_r[g].rd <= ptr_r[g].rd + 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // controller read bursts

    logic pri_rd;
    logic [DRBI_WORD_W-1:0] reply_data_r;
    logic reply_valid_r;

    assign pri_rd = rd_hit[role_r];

    // commands during a burst or in diagnostics are ignored
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            burst_cnt_r <= 3'h0;
        else if (ctrl_r.diag || clr_all)
            burst_cnt_r <= 3'h0;
        else if (burst_cnt_r == 3'h0)
        begin
            if (read_six_words_cmd)
                burst_cnt_r <= DRBI_BURST_SIX;
            else if (read_four_words_cmd)
                burst_cnt_r <= DRBI_BURST_FOUR;
        end
        else if (pri_rd)
            burst_cnt_r <= burst_cnt_r - 3'h1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reply_data_r <= '0;
            reply_valid_r <= 1'b0;
        end
        else
        begin
            reply_valid_r <= pri_rd;
            if (pri_rd)
                reply_data_r <= rd_word[role_r];
        end
    end

    assign reply_data = reply_data_r;
    assign reply_data_valid = reply_valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // register read mux

    always_comb
    begin
        rd_mux = DRBI_ZERO_WORD;
        case (paddr)
            DRBI_CTRL_OFS:
            begin
                rd_mux[DRBI_CTRL_WSEL_BIT] = ctrl_r.wsel;
                rd_mux[DRBI_CTRL_DIAG_BIT] = ctrl_r.diag;
            end
            DRBI_STATUS_OFS:
            begin
                rd_mux[DRBI_STAT_ROLE_BIT] = role_r;
                rd_mux[DRBI_STAT_BUSY_BIT] = burst_cnt_r != 3'h0;
            end
            DRBI_PTR1_OFS:
            begin
                rd_mux[DRBI_PTR_WR_LSB +: ADDR_W] = ptr_r[0].wr;
                rd_mux[DRBI_PTR_RD_LSB +: ADDR_W] = ptr_r[0].rd;
            end
            DRBI_PTR2_OFS:
            begin
                rd_mux[DRBI_PTR_WR_LSB +: ADDR_W] = ptr_r[1].wr;
                rd_mux[DRBI_PTR_RD_LSB +: ADDR_W] = ptr_r[1].rd;
            end
            // diagnostic peek at primary or secondary memory, as steered by buffer-role select
            DRBI_DIAG_DATA_OFS: rd_mux[DRBI_WORD_W-1:0] = rd_word[diag_target];
            default: rd_mux = DRBI_ZERO_WORD;
        endcase
    end

endmodule

// file: drbi_assertions.sv
`timescale 1ns/1ps

module drbi_assertions
    import drbi_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb
    input wire logic [DRBI_PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic role_swap_pulse,
    input wire logic reply_data_valid,
    input wire logic primary_is_two
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered after one wait state");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match the address map");
    a_swap_toggles: assert property ($rose(role_swap_pulse) |-> ##[2:4] $changed(primary_is_two))
        else $error("swap pulse did not exchange roles");
    a_swap_synced: assert property ($rose(role_swap_pulse) |=> $stable(primary_is_two))
        else $error("role changed before the pulse was synchronised");
    a_role_cause: assert property ($changed(primary_is_two) |->
        $past(role_swap_pulse, 2) || $past(role_swap_pulse, 3) || $past(role_swap_pulse, 4))
        else $error("role changed without a swap pulse");
    a_burst_max: assert property (reply_data_valid [*6] |=> !reply_data_valid)
        else $error("more than six reply words in a row");
endmodule

bind drbi_top drbi_assertions u_drbi_assertions (
    .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .role_swap_pulse(role_swap_pulse),
    .reply_data_valid(reply_data_valid), .primary_is_two(primary_is_two)
);

// file: drbi_ctrl_model.sv
`timescale 1ns/1ps

module drbi_ctrl_model
    import drbi_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // bench request
    input wire logic burst_req,
    input wire logic burst_six,
    // buffer side
    input wire logic [DRBI_WORD_W-1:0] reply_data,
    input wire logic reply_data_valid,
    output logic read_four_words_cmd,
    output logic read_six_words_cmd
);
    logic [DRBI_WORD_W-1:0] words[$];

    initial
    begin
        read_four_words_cmd = 1'b0;
        read_six_words_cmd = 1'b0;
    end

    // command follows the request each cycle, so a held request starts a new burst once one ends
    always @(posedge sys_clk)
    begin
        read_four_words_cmd <= burst_req && !burst_six;
        read_six_words_cmd <= burst_req && burst_six;
        if (reply_data_valid === 1'b1)
            words.push_back(reply_data);
    end
endmodule

// file: dual_reply_buffer_interface_test.sv
`timescale 1ns/1ps

module dual_reply_buffer_interface_test
    import drbi_pkg::*;
;
    logic sys_clk;
    logic arst_n;
    logic [DRBI_PADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic role_swap_pulse;
    logic missed_interrogation_clear;
    logic host_write_strobe;
    logic [DRBI_WORD_W-1:0] host_wr_data;
    logic read_four_words_cmd;
    logic read_six_words_cmd;
    logic [DRBI_WORD_W-1:0] reply_data;
    logic reply_data_valid;
    logic primary_is_two;
    logic burst_req;
    logic burst_six;
    logic [31:0] q;
    logic e;
    int bad_count;
    int checks_done;

    drbi_top DUT (
        .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .role_swap_pulse(role_swap_pulse), .missed_interrogation_clear(missed_interrogation_clear),
        .host_write_strobe(host_write_strobe), .host_wr_data(host_wr_data),
        .read_four_words_cmd(read_four_words_cmd), .read_six_words_cmd(read_six_words_cmd),
        .reply_data(reply_data), .reply_data_valid(reply_data_valid),
        .primary_is_two(primary_is_two)
    );

    drbi_ctrl_model u_ctrl (
        .sys_clk(sys_clk), .burst_req(burst_req), .burst_six(burst_six),
        .reply_data(reply_data), .reply_data_valid(reply_data_valid),
        .read_four_words_cmd(read_four_words_cmd), .read_six_words_cmd(read_six_words_cmd)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge sys_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n == 16)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, DRBI_ZERO_WORD);
        chk(q, exp);
    endtask

    // data settles a clock ahead of the strobe, since both pass separate synchronisers
    task automatic hostw(input logic [DRBI_WORD_W-1:0] d);
        host_wr_data <= d;
        @(posedge sys_clk);
        host_write_strobe <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host_write_strobe <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic pin(input logic clr);
        role_swap_pulse <= !clr;
        missed_interrogation_clear <= clr;
        repeat (4) @(posedge sys_clk);
        role_swap_pulse <= 1'b0;
        missed_interrogation_clear <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic burst(input logic six, input int total);
        int n;
        n = 0;
        burst_six <= six;
        burst_req <= 1'b1;
        @(posedge sys_clk);
        burst_req <= 1'b0;
        while (u_ctrl.words.size() < total && n < 40)
        begin
            n++;
            @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
        chk(32'(u_ctrl.words.size()), 32'(total));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'b0;
        {paddr, psel, penable, pwrite, pwdata, burst_req, burst_six} = '0;
        {role_swap_pulse, missed_interrogation_clear, host_write_strobe, host_wr_data} = '0;
        bad_count = 0;
        checks_done = 0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rd(DRBI_PTR1_OFS, DRBI_ZERO_WORD);
        rd(DRBI_PTR2_OFS, DRBI_ZERO_WORD);
        rd(DRBI_STATUS_OFS, DRBI_ZERO_WORD);
        apb(8'h14, 1'b0, DRBI_ZERO_WORD);
        chk({31'h0, e}, 32'h0000_0001);
        for (int i = 0; i < 4; i++)
            hostw(16'hA000 + 16'(i));
        rd(DRBI_PTR1_OFS, 32'h0000_0004);
        burst(1'b0, 4);
        for (int i = 0; i < 4; i++)
            chk(32'(u_ctrl.words[i]), 32'h0000_A000 + 32'(i));
        rd(DRBI_PTR1_OFS, 32'h0004_0004);
        apb(DRBI_CTRL_OFS, 1'b1, 32'h0000_0001);
        for (int i = 0; i < 6; i++)
            hostw(16'h5000 + 16'(i));
        rd(DRBI_PTR2_OFS, 32'h0000_0006);
        rd(DRBI_PTR1_OFS, 32'h0004_0004);
        pin(1'b0);
        rd(DRBI_STATUS_OFS, 32'h0000_0001);
        chk({31'h0, primary_is_two}, 32'h0000_0001);
        rd(DRBI_PTR2_OFS, 32'h0000_0006);
        burst(1'b1, 10);
        for (int i = 0; i < 6; i++)
            chk(32'(u_ctrl.words[4 + i]), 32'h0000_5000 + 32'(i));
        rd(DRBI_PTR2_OFS, 32'h0006_0006);
        // one full lap of the secondary write pointer
        for (int i = 0; i < 1024; i++)
            hostw(16'(i));
        rd(DRBI_PTR1_OFS, 32'h0004_0004);
        apb(DRBI_CTRL_OFS, 1'b1, 32'h0000_0005);
        rd(DRBI_CTRL_OFS, 32'h0000_0001);
        rd(DRBI_PTR1_OFS, DRBI_ZERO_WORD);
        rd(DRBI_PTR2_OFS, DRBI_ZERO_WORD);
        hostw(16'h1234);
        rd(DRBI_PTR1_OFS, 32'h0000_0001);
        // diagnostics: controller locked out, host peeks and steps the read pointer
        apb(DRBI_CTRL_OFS, 1'b1, 32'h0000_0003);
        burst(1'b0, 10);
        rd(DRBI_DIAG_DATA_OFS, 32'h0000_1234);
        apb(DRBI_CTRL_OFS, 1'b1, 32'h0000_000B);
        rd(DRBI_PTR1_OFS, 32'h0001_0001);
        rd(DRBI_DIAG_DATA_OFS, 32'h0000_03FD);
        apb(DRBI_CTRL_OFS, 1'b1, 32'h0000_0001);
        pin(1'b1);
        rd(DRBI_PTR1_OFS, DRBI_ZERO_WORD);
        rd(DRBI_STATUS_OFS, 32'h0000_0001);
        pin(1'b0);
        chk({31'h0, primary_is_two}, DRBI_ZERO_WORD);
        rd(DRBI_STATUS_OFS, DRBI_ZERO_WORD);
        report_and_stop();
    end
endmodule
